/* rtl/mebi_top.sv */
// Purpose: External pin interface of a single-chip 8-bit microcomputer
// Assumes: Core presents one request per machine cycle; pins synchronous
// Notes:   Five phases per machine cycle, each PH_CLKS clocks long
`timescale 1ns/100ps
module mebi_top
  import mebi_pkg::*;
#(
  parameter int unsigned PH_CLKS   = PHASE_CLKS_DEF,
  parameter int unsigned ROM_WORDS = INT_ROM_WORDS
)(
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire mebi_req_t  req_i,
  input  wire mebi_ctl_t  ctl_i,
  output mebi_rsp_t       rsp_o,
  output logic            accept_o,
  output logic            halted_o,
  output mebi_lvl_t       test_lvl_o,
  output logic            int_req_o,
  output logic            count_evt_o,
  input  wire logic       force_external_fetch_i,
  input  wire logic       single_step_n_i,
  input  wire logic       int_n_i,
  input  wire logic       test_input_zero_i,
  output logic            test_input_zero_o,
  output logic            test_input_zero_oe_n_o,
  input  wire logic       test_input_one_i,
  output logic            addr_latch_o,
  output logic            read_strobe_n_o,
  output logic            write_strobe_n_o,
  output logic            expander_strobe_store_strobe_n_o,
  output logic            expander_strobe_o,
  input  wire logic [7:0] mux_bus_lines_i,
  output logic [7:0]      mux_bus_lines_o,
  output logic            mux_bus_lines_oe_n_o,
  input  wire logic [7:0] first_port_lines_i,
  output logic [7:0]      first_port_lines_o,
  input  wire logic [7:0] second_port_lines_i,
  output logic [7:0]      second_port_lines_o
);

  if (ROM_WORDS > 4096) begin : g_chk
    $error("Internal program store larger than address space");
  end

  typedef struct packed {
    mebi_phase_t phase;
    mebi_req_t   cur;
    logic        ext;        // Current fetch goes off chip
    logic        accept;
    logic        halted;
    logic        ale;
    logic        rd_n;
    logic        wr_n;
    logic        pstb_n;
    logic        exp_stb;
    logic [7:0]  bus_out;
    logic        bus_oe_n;
    logic [7:0]  bus_latch;
    logic        bus_static;
    logic [7:0]  p1;
    logic [7:0]  p2;         // Port two latch
    logic [7:0]  p2_drv;     // Port two lines as driven
    logic        clk_out_mode;
    logic        t0_out;
    logic        t0_oe_n;
    logic        count_mode;
    logic        ev_prev;
    logic        cnt_evt;
    logic        int_en;
    logic        int_req;
    mebi_lvl_t   lvl;
    mebi_rsp_t   rsp;
  } mebi_st_t;

  mebi_st_t s_q;
  mebi_st_t s_d;
  logic     tick;

  mebi_tick_div #(
    .DIV     (PH_CLKS)
  ) u_div (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .tick_o  (tick)
  );

  ////////////////////////////////////////////////////////////////////////
  // Decoding helpers
  function automatic logic bus_kind(mebi_kind_t k);
    return k inside {K_DRD, K_DWR, K_BUSRD, K_BUSWR};
  endfunction

  function automatic logic fetch_ext(mebi_req_t r, logic frc);
    return (r.kind == K_FETCH) && (frc || 32'(r.addr) >= ROM_WORDS);
  endfunction

  function automatic logic is_exp(mebi_kind_t k);
    return k inside {K_EXRD, K_EXWR};
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    s_d = s_q;
    s_d.accept   = 1'b0;
    s_d.rsp.done = 1'b0;
    s_d.cnt_evt  = 1'b0;

    // Pin levels for jumps, counter input, interrupt gating
    s_d.lvl = '{test0: test_input_zero_i, test1: test_input_one_i,
                int_n: int_n_i};
    s_d.ev_prev = test_input_one_i;
    if (ctl_i.start_counter_instr) begin
      s_d.count_mode = 1'b1;
    end else if (ctl_i.stop_counter_instr) begin
      s_d.count_mode = 1'b0;
    end
    s_d.cnt_evt = s_q.count_mode & s_q.ev_prev & ~test_input_one_i;
    if (ctl_i.clock_out_enable_instr) begin
      s_d.clk_out_mode = 1'b1;
    end
    // Only the enabled mode drives the pin; it toggles once per phase
    s_d.t0_oe_n = ~s_d.clk_out_mode;
    if (s_q.clk_out_mode && tick) begin
      s_d.t0_out = ~s_q.t0_out;
    end
    if (ctl_i.int_enable_instr) begin
      s_d.int_en = 1'b1;
    end else if (ctl_i.int_disable_instr) begin
      s_d.int_en = 1'b0;
    end
    s_d.int_req = s_d.int_en & ~int_n_i;

    if (tick) begin
      unique case (s_q.phase)
        PH_ADDR: begin
          // Address stays on the lines across the latch falling edge
          s_d.ale   = 1'b0;
          s_d.phase = PH_HOLD;
        end
        PH_HOLD: begin
          s_d.phase = PH_STRB;
          unique case (s_q.cur.kind)
            K_FETCH: begin
              if (s_q.ext) begin
                s_d.pstb_n   = 1'b0;
                s_d.bus_oe_n = 1'b1;
              end
            end
            K_DRD, K_BUSRD: begin
              s_d.rd_n     = 1'b0;
              s_d.bus_oe_n = 1'b1;
            end
            K_DWR, K_BUSWR: begin
              s_d.bus_out  = s_q.cur.wdata;
              s_d.bus_oe_n = 1'b0;
              s_d.wr_n     = 1'b0;
            end
            K_EXRD: begin
              s_d.exp_stb     = 1'b0;
              s_d.p2_drv[3:0] = NIBBLE_FLOAT;
            end
            K_EXWR: begin
              s_d.exp_stb     = 1'b0;
              s_d.p2_drv[3:0] = s_q.cur.wdata[3:0];
            end
            default: ;
          endcase
        end
        PH_STRB: begin
          s_d.phase = PH_SAMP;
        end
        PH_SAMP: begin
          // Sample on the same edge that releases the strobe
          s_d.phase    = PH_DONE;
          s_d.rsp.done = 1'b1;
          s_d.rd_n     = 1'b1;
          s_d.wr_n     = 1'b1;
          s_d.pstb_n   = 1'b1;
          s_d.exp_stb  = 1'b1;
          unique case (s_q.cur.kind)
            K_FETCH: begin
              s_d.rsp.rdata = s_q.ext ? mux_bus_lines_i : 8'h00;
            end
            K_DRD, K_BUSRD: begin
              s_d.rsp.rdata  = mux_bus_lines_i;
              s_d.bus_static = 1'b0;
            end
            K_BUSLAT: begin
              s_d.bus_latch  = s_q.cur.wdata;
              s_d.bus_static = 1'b1;
            end
            K_P1RD: s_d.rsp.rdata = first_port_lines_i & s_q.p1;
            K_P2RD: s_d.rsp.rdata = second_port_lines_i & s_q.p2;
            K_P1WR: s_d.p1 = s_q.cur.wdata;
            K_P2WR: s_d.p2 = s_q.cur.wdata;
            K_EXRD: begin
              s_d.rsp.rdata = {4'h0, second_port_lines_i[3:0]};
            end
            default: ;
          endcase
          if (fetch_ext(s_q.cur, 1'b0) && !s_q.ext) begin
            s_d.bus_static = 1'b0;
          end
          if (s_q.cur.kind == K_FETCH && s_q.ext) begin
            s_d.bus_static = 1'b0;
          end
        end
        PH_DONE: begin
          // Restore the port and bus resting values between cycles
          s_d.p2_drv   = s_q.p2;
          s_d.bus_out  = s_q.bus_latch;
          s_d.bus_oe_n = ~s_q.bus_static;
          if (s_q.halted) begin
            s_d.halted = ~single_step_n_i;
          end else if (s_q.cur.last && !single_step_n_i) begin
            // Halt with no latch pulse until the step input rises
            s_d.halted = 1'b1;
          end else begin
            s_d.phase  = PH_ADDR;
            s_d.accept = 1'b1;
            s_d.cur    = req_i;
            s_d.ale    = 1'b1;
            s_d.ext    = fetch_ext(req_i, force_external_fetch_i);
            if (s_d.ext || bus_kind(req_i.kind)) begin
              s_d.bus_out  = req_i.addr[7:0];
              s_d.bus_oe_n = 1'b0;
            end
            if (s_d.ext) begin
              s_d.p2_drv[3:0] = req_i.addr[11:8];
            end
            if (is_exp(req_i.kind)) begin
              s_d.p2_drv[3:0] = {(req_i.kind == K_EXWR) ? EXP_OP_WR
                                 : EXP_OP_RD, req_i.addr[1:0]};
            end
          end
        end
        default: s_d.phase = PH_DONE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // State register; reset puts every pin at rest
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_q <= '{phase: PH_DONE, cur: '{kind: K_IDLE, default: '0},
               rd_n: 1'b1, wr_n: 1'b1, pstb_n: 1'b1, exp_stb: 1'b1,
               bus_out: BUS_RST, bus_oe_n: 1'b1, bus_latch: BUS_RST,
               p1: PORT_RST, p2: PORT_RST, p2_drv: PORT_RST,
               t0_oe_n: 1'b1, ev_prev: 1'b1,
               lvl: '{default: 1'b1}, default: '0};
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs straight from the state register
  assign rsp_o                  = s_q.rsp;
  assign accept_o               = s_q.accept;
  assign halted_o               = s_q.halted;
  assign test_lvl_o             = s_q.lvl;
  assign int_req_o              = s_q.int_req;
  assign count_evt_o            = s_q.cnt_evt;
  assign test_input_zero_o      = s_q.t0_out;
  assign test_input_zero_oe_n_o = s_q.t0_oe_n;
  assign addr_latch_o           = s_q.ale;
  assign read_strobe_n_o        = s_q.rd_n;
  assign write_strobe_n_o       = s_q.wr_n;
  assign expander_strobe_store_strobe_n_o  = s_q.pstb_n;
  assign expander_strobe_o      = s_q.exp_stb;
  assign mux_bus_lines_o        = s_q.bus_out;
  assign mux_bus_lines_oe_n_o   = s_q.bus_oe_n;
  assign first_port_lines_o     = s_q.p1;
  assign second_port_lines_o    = s_q.p2_drv;

  ////////////////////////////////////////////////////////////////////////
  // Checks; cycle figures assume the default phase length of two clocks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_latch_fall;
    s_q.ale ##1 !s_q.ale;
  endsequence

  sequence s_store_data;
    $fell(s_q.wr_n) && !s_q.bus_oe_n && s_q.bus_out == s_q.cur.wdata;
  endsequence

  property p_ale_gap;
    s_latch_fall |-> (!s_q.ale)[*8];
  endproperty
  a_ale_gap: assert property (p_ale_gap)
    else $error("Latch pulse repeated inside a machine cycle");

  property p_strobe_after_ale;
    ($fell(s_q.rd_n) || $fell(s_q.pstb_n)) |-> !s_q.ale && !$past(s_q.ale);
  endproperty
  a_strobe_after_ale: assert property (p_strobe_after_ale)
    else $error("Read strobe overlaps the latch pulse");

  property p_pstb_ext;
    !s_q.pstb_n |-> s_q.cur.kind == K_FETCH && s_q.ext && s_q.bus_oe_n;
  endproperty
  a_pstb_ext: assert property (p_pstb_ext)
    else $error("Program store strobe outside an external fetch");

  property p_pc_nibble;
    !s_q.pstb_n |-> s_q.p2_drv[3:0] == s_q.cur.addr[11:8];
  endproperty
  a_pc_nibble: assert property (p_pc_nibble)
    else $error("Upper program counter nibble missing");

  property p_rd_kind;
    !s_q.rd_n |-> s_q.cur.kind inside {K_DRD, K_BUSRD} && s_q.bus_oe_n;
  endproperty
  a_rd_kind: assert property (p_rd_kind)
    else $error("Read strobe on a cycle that is no read");

  property p_store_seq;
    (s_q.ale && s_q.cur.kind == K_DWR) |->
      s_q.bus_out == s_q.cur.addr[7:0] ##[1:8] s_store_data;
  endproperty
  a_store_seq: assert property (p_store_seq)
    else $error("Data store did not give address then data");

  property p_force;
    (s_q.accept && s_q.cur.kind == K_FETCH && $past(force_external_fetch_i))
      |-> ##[1:8] !s_q.pstb_n;
  endproperty
  a_force: assert property (p_force)
    else $error("Forced fetch stayed internal");

  property p_int_gate;
    (s_q.int_en && !int_n_i && !ctl_i.int_disable_instr) |=> s_q.int_req;
  endproperty
  a_int_gate: assert property (p_int_gate)
    else $error("Enabled low interrupt not raised");

  property p_int_stay_off;
    (!s_q.int_en && !ctl_i.int_enable_instr) |=> !s_q.int_en && !s_q.int_req;
  endproperty
  a_int_stay_off: assert property (p_int_stay_off)
    else $error("Interrupt enabled without the enable instruction");

  property p_halt;
    s_q.halted |-> !s_q.ale && s_q.phase == PH_DONE;
  endproperty
  a_halt: assert property (p_halt)
    else $error("Latch pulse while single stepped");

  property p_clk_out;
    ($fell(s_q.t0_oe_n) |-> $past(ctl_i.clock_out_enable_instr)) and
    ((!s_q.t0_oe_n && tick) |=> s_q.t0_out != $past(s_q.t0_out));
  endproperty
  a_clk_out: assert property (p_clk_out)
    else $error("Test zero driven before clock output enabled");

  property p_count;
    s_q.cnt_evt |-> $past(s_q.count_mode) && $past(test_input_one_i, 2)
                    && !$past(test_input_one_i);
  endproperty
  a_count: assert property (p_count)
    else $error("Counter event without a falling test one edge");

endmodule

/* rtl/mebi_pkg.sv */
// Purpose: Shared constants and carrier types for the external bus block
// Assumes: One 200 MHz clock; the core issues one bus request per cycle
// Notes:   Phase length and internal program store size set here
package mebi_pkg;

  ////////////////////////////////////////////////////////////////////////
  // Timing and sizes
  localparam real         CLK_PERIOD_NS  = 5.0;
  localparam int unsigned PHASE_CLKS_DEF = 2;     // Clocks per bus phase
  localparam int unsigned PHASE_CLKS_MAX = 255;
  localparam int unsigned INT_ROM_WORDS  = 1024;  // Internal program store

  ////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [7:0]  BUS_RST        = 8'h00;
  localparam logic [7:0]  PORT_RST       = 8'hff; // Quasi lines float high
  localparam logic [3:0]  NIBBLE_FLOAT   = 4'hf;

  ////////////////////////////////////////////////////////////////////////
  // Expander code nibble: op in bits 3:2, port in bits 1:0
  localparam logic [1:0]  EXP_OP_RD      = 2'b00;
  localparam logic [1:0]  EXP_OP_WR      = 2'b01;

  // Bus cycle kinds requested by the core
  typedef enum logic [3:0] {
    K_IDLE, K_FETCH, K_DRD, K_DWR, K_BUSRD, K_BUSWR, K_BUSLAT,
    K_P1RD, K_P1WR, K_P2RD, K_P2WR, K_EXRD, K_EXWR
  } mebi_kind_t;

  // Phases of one machine cycle
  typedef enum logic [2:0] {
    PH_ADDR, PH_HOLD, PH_STRB, PH_SAMP, PH_DONE
  } mebi_phase_t;

  typedef struct packed {
    mebi_kind_t  kind;
    logic [11:0] addr;   // Program counter, data address or expander port
    logic [7:0]  wdata;
    logic        last;   // Final cycle of the current instruction
  } mebi_req_t;

  typedef struct packed {
    logic        done;
    logic [7:0]  rdata;
  } mebi_rsp_t;

  // One-cycle pulses from the instruction decoder
  typedef struct packed {
    logic        start_counter_instr;
    logic        stop_counter_instr;
    logic        clock_out_enable_instr;
    logic        int_enable_instr;
    logic        int_disable_instr;
  } mebi_ctl_t;

  // Pin levels for the conditional jumps
  typedef struct packed {
    logic        test0;
    logic        test1;
    logic        int_n;
  } mebi_lvl_t;

endpackage

/* rtl/mebi_tick_div.sv */
// Purpose: Divides the clock into a one-cycle phase enable
// Assumes: DIV clock cycles per phase
// Notes:   Free running so the address latch keeps a steady rate
`timescale 1ns/100ps
module mebi_tick_div
  import mebi_pkg::*;
#(
  parameter int unsigned DIV = PHASE_CLKS_DEF
)(
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  output logic      tick_o
);

  typedef struct packed {
    logic [7:0] cnt;
    logic       tick;
  } mebi_div_st_t;

  localparam logic [7:0] LAST = 8'(DIV - 1);

  mebi_div_st_t s_q;
  mebi_div_st_t s_d;

  if (DIV < 1 || DIV > PHASE_CLKS_MAX) begin : g_chk
    $error("Phase divider out of range");
  end

  ////////////////////////////////////////////////////////////////////////
  // Count up one phase, pulse at its end
  always_comb begin
    s_d = s_q;
    s_d.tick = 1'b0;
    if (s_q.cnt == LAST) begin
      s_d.cnt  = 8'h00;
      s_d.tick = 1'b1;
    end else begin
      s_d.cnt = s_q.cnt + 8'h01;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign tick_o = s_q.tick;

endmodule

/* bench/mebi_ext_mem.sv */
// Purpose: External program/data memory and port expander model
// Assumes: Strobes come from mebi_top; one clock domain
// Notes:   Answers at once; an undriven bus toggles so stale data shows
`timescale 1ns/100ps
module mebi_ext_mem
  import mebi_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       ale_i,
  input  wire logic       rd_n_i,
  input  wire logic       wr_n_i,
  input  wire logic       pstb_n_i,
  input  wire logic       exp_strobe_i,
  input  wire logic [7:0] bus_dev_i,
  input  wire logic       bus_oe_n_i,
  input  wire logic [7:0] p2_dev_i,
  output logic [7:0]      bus_o,
  output logic [7:0]      p2_o
);
  logic [11:0] addr_q;
  logic [7:0]  dmem [256];
  logic [3:0]  eport_q [4];
  logic [3:0]  code_q;
  logic        flip_q;

  ////////////////////////////////////////////////////////////
  // Address taken on the falling latch edge only
  always @(negedge ale_i) begin
    addr_q <= {p2_dev_i[3:0], bus_dev_i};
  end

  // Store on the trailing write edge, data still on the bus
  always @(posedge wr_n_i) begin
    dmem[addr_q[7:0]] <= bus_dev_i;
  end

  // Expander code follows port two while the strobe idles high, held while it is low
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      flip_q <= 1'b0;
      code_q <= 4'h0;
    end else begin
      flip_q <= ~flip_q;
      if (exp_strobe_i) begin
        code_q <= p2_dev_i[3:0];
      end else if (code_q[3:2] == EXP_OP_WR) begin
        eport_q[code_q[1:0]] <= p2_dev_i[3:0];
      end
    end
  end

  // Data stays valid exactly while a read strobe is low
  always_comb begin
    if (!bus_oe_n_i)
      bus_o = bus_dev_i;
    else if (!pstb_n_i)
      bus_o = addr_q[7:0] ^ {addr_q[11:8], 4'h5};
    else if (!rd_n_i)
      bus_o = dmem[addr_q[7:0]];
    else
      bus_o = {8{flip_q}};
  end

  // Quasi lines: the expander can only pull down
  assign p2_o[7:4] = p2_dev_i[7:4];
  assign p2_o[3:0] = (!exp_strobe_i && code_q[3:2] == EXP_OP_RD) ?
                     eport_q[code_q[1:0]] & p2_dev_i[3:0] : p2_dev_i[3:0];
endmodule

/* bench/testbench.sv */
// Purpose: Self-checking bench for the external bus block
// Assumes: PH_CLKS of 2, so a strobe stays low for four clocks
// Notes:   Bus and port two levels are resolved by the memory model
`timescale 1ns/100ps
module testbench;
  import mebi_pkg::*;
  localparam int PH  = 2;
  localparam int STB = 2 * PH;
  logic       clk = 0, rst_n = 0, accept, halted, int_req, cnt_evt;
  logic       force_ext = 0, ss_n = 1, int_n = 1, t0_ext = 0, tst1 = 0;
  logic       t0_o, t0_oe_n, t0_i, ale, rd_n, wr_n, pstb_n, exp_stb;
  logic       bus_oe_n, c0_ale, c0_oe;
  logic [7:0] bus_i, bus_o, p1_i, p1_o, p2_i, p2_o, c0_bus;
  logic [7:0] p1_ext = 8'hff;
  logic [3:0] c0_p2;
  mebi_req_t  req = '{K_IDLE, 12'h000, 8'h00, 1'b0};
  mebi_ctl_t  ctl = '0;
  mebi_rsp_t  rsp;
  mebi_lvl_t  lvl;
  int         failures = 0, checks = 0, i;
  int         n [6];

  always #2.5 clk = ~clk;
  assign p1_i = p1_o & p1_ext;
  assign t0_i = t0_oe_n ? t0_ext : t0_o;

  ////////////////////////////////////////////////////////////
  mebi_top #(.PH_CLKS(PH)) i_mebi_top (
    .clk_i(clk), .rst_n_i(rst_n), .req_i(req), .ctl_i(ctl), .rsp_o(rsp),
    .accept_o(accept), .halted_o(halted), .test_lvl_o(lvl),
    .int_req_o(int_req), .count_evt_o(cnt_evt),
    .force_external_fetch_i(force_ext), .single_step_n_i(ss_n),
    .int_n_i(int_n), .test_input_zero_i(t0_i), .test_input_zero_o(t0_o),
    .test_input_zero_oe_n_o(t0_oe_n), .test_input_one_i(tst1),
    .addr_latch_o(ale), .read_strobe_n_o(rd_n), .write_strobe_n_o(wr_n),
    .expander_strobe_store_strobe_n_o(pstb_n), .expander_strobe_o(exp_stb),
    .mux_bus_lines_i(bus_i), .mux_bus_lines_o(bus_o),
    .mux_bus_lines_oe_n_o(bus_oe_n), .first_port_lines_i(p1_i),
    .first_port_lines_o(p1_o), .second_port_lines_i(p2_i),
    .second_port_lines_o(p2_o));

  mebi_ext_mem i_mebi_ext_mem (
    .clk_i(clk), .rst_n_i(rst_n), .ale_i(ale), .rd_n_i(rd_n),
    .wr_n_i(wr_n), .pstb_n_i(pstb_n), .exp_strobe_i(exp_stb),
    .bus_dev_i(bus_o), .bus_oe_n_i(bus_oe_n), .p2_dev_i(p2_o),
    .bus_o(bus_i), .p2_o(p2_i));

  ////////////////////////////////////////////////////////////
  // Compare and count; unknown bits match only unknown bits
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic lost(input int cnt, input int lim);
    if (cnt >= lim) begin
      failures++;
      $display("[FAIL] %0t wait ran out", $time);
      print_verdict();
    end
  endtask

  // Inputs always move 1 ns after the rising edge
  task automatic tick();
    @(posedge clk);
    #1;
  endtask

  task automatic pulse(input logic [4:0] v);
    ctl = mebi_ctl_t'(v);
    tick();
    ctl = '0;
  endtask

  // One machine cycle: strobe lows counted until done
  task automatic issue(input mebi_kind_t k, input logic [11:0] a,
                       input logic [7:0] w, input logic last);
    req = '{k, a, w, last};
    i = 0;
    do begin
      tick();
      i++;
    end while (accept !== 1'b1 && i < 40);
    lost(i, 40);
    {c0_ale, c0_oe, c0_p2, c0_bus} = {ale, bus_oe_n, p2_o[3:0], bus_o};
    req.kind = K_IDLE;
    n = '{default: 0};
    i = 0;
    do begin
      n[0] += ale;
      n[1] += !pstb_n;
      n[2] += !rd_n;
      n[3] += !wr_n;
      n[4] += !exp_stb;
      n[5] += ale & (!pstb_n | !rd_n | !wr_n);
      tick();
      i++;
    end while (rsp.done !== 1'b1 && i < 40);
    lost(i, 40);
  endtask

  // Latch high for one phase, given strobe counts, no overlap
  task automatic counts(input int ps, input int rd, input int wr,
                        input int ex);
    check(n[0], PH);
    check(n[1], ps);
    check(n[2], rd);
    check(n[3], wr);
    check(n[4], ex);
    check(n[5], 0);
  endtask

  task automatic addr_seen(input logic [11:0] a, input logic fetch);
    check({c0_ale, c0_oe, c0_bus}, {2'b10, a[7:0]});
    if (fetch)
      check(c0_p2, a[11:8]);
  endtask

  ////////////////////////////////////////////////////////////
  // Fetches, data memory and port traffic
  task automatic bus_traffic();
    force_ext = 1'b1;
    issue(K_FETCH, 12'h3a7, 8'h00, 1'b0);
    addr_seen(12'h3a7, 1'b1);
    counts(STB, 0, 0, 0);
    check(rsp.rdata, 8'ha7 ^ 8'h35);
    force_ext = 1'b0;
    issue(K_FETCH, 12'h010, 8'h00, 1'b0);
    counts(0, 0, 0, 0);
    check(rsp.rdata, 8'h00);
    issue(K_FETCH, 12'h5c3, 8'h00, 1'b0);
    addr_seen(12'h5c3, 1'b1);
    check(rsp.rdata, 8'hc3 ^ 8'h55);
    issue(K_DWR, 12'h04e, 8'h9b, 1'b0);
    addr_seen(12'h04e, 1'b0);
    counts(0, 0, STB, 0);
    issue(K_DRD, 12'h04e, 8'h00, 1'b0);
    counts(0, STB, 0, 0);
    check(rsp.rdata, 8'h9b);
    issue(K_BUSWR, 12'h000, 8'h21, 1'b0);
    counts(0, 0, STB, 0);
    issue(K_BUSRD, 12'h000, 8'h00, 1'b0);
    counts(0, STB, 0, 0);
    check(rsp.rdata, 8'h21);
    issue(K_BUSLAT, 12'h000, 8'h66, 1'b0);
    repeat (3) tick();
    check({bus_oe_n, bus_o}, {1'b0, 8'h66});
    issue(K_EXWR, 12'h002, 8'h0a, 1'b0);
    counts(0, 0, 0, STB);
    issue(K_EXRD, 12'h002, 8'h00, 1'b0);
    check(rsp.rdata[3:0], 4'ha);
    issue(K_P1WR, 12'h000, 8'h5a, 1'b0);
    check(p1_o, 8'h5a);
    p1_ext = 8'h0f;
    issue(K_P1RD, 12'h000, 8'h00, 1'b0);
    check(rsp.rdata, 8'h0a);
    issue(K_P2WR, 12'h000, 8'hc3, 1'b0);
    repeat (3) tick();
    check(p2_o, 8'hc3);
    issue(K_P2RD, 12'h000, 8'h00, 1'b0);
    check(rsp.rdata, 8'hc3);
  endtask

  // Interrupt gating and the two test inputs
  task automatic pins();
    int_n = 1'b0;
    repeat (3) tick();
    check({int_req, lvl.int_n}, 2'b00);
    pulse(5'b00010);
    tick();
    check(int_req, 1'b1);
    pulse(5'b00001);
    tick();
    check(int_req, 1'b0);
    int_n = 1'b1;
    tst1 = 1'b1;
    repeat (3) tick();
    check(lvl.test1, 1'b1);
    for (int m = 0; m < 3; m++) begin
      pulse(m == 1 ? 5'b10000 : m == 2 ? 5'b01000 : 5'b00000);
      tst1 = 1'b0;
      n[0] = 0;
      repeat (6) begin
        tick();
        n[0] += cnt_evt;
      end
      check(n[0], m == 1);
      tst1 = 1'b1;
      repeat (2) tick();
    end
    t0_ext = 1'b1;
    repeat (3) tick();
    check({t0_oe_n, lvl.test0}, 2'b11);
    pulse(5'b00100);
    repeat (2) tick();
    n[0] = 0;
    repeat (20) begin
      c0_ale = t0_o;
      tick();
      n[0] += (t0_o !== c0_ale);
    end
    check({t0_oe_n, n[0][4:0]}, {1'b0, 5'h0a});
  endtask

  // Halt after a last cycle, resume when released
  task automatic single_step();
    ss_n = 1'b0;
    issue(K_FETCH, 12'h010, 8'h00, 1'b1);
    for (i = 0; i < 10 && halted !== 1'b1; i++) tick();
    lost(i, 10);
    n[0] = 0;
    repeat (20) begin
      tick();
      n[0] += ale;
    end
    check(n[0], 0);
    ss_n = 1'b1;
    for (i = 0; i < 30 && ale !== 1'b1; i++) tick();
    lost(i, 30);
    check({ale, halted}, 2'b10);
  endtask

  ////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge clk);
    #1;
    check({pstb_n, rd_n, wr_n, exp_stb, ale, bus_oe_n}, 6'h3d);
    check({p1_o, p2_o, int_req, t0_oe_n}, 18'h3fffd);
    @(posedge clk);
    #1;
    rst_n = 1'b1;
    bus_traffic();
    pins();
    single_step();
    print_verdict();
  end
endmodule
